// File: dv/amrc_host_model.sv
// Host processor model driving the parallel configuration bus
`timescale 1ns/1ps
module amrc_host_model (
    input  wire logic        clk,
    input  wire logic [11:0] data_out,
    output logic             cs_n,
    output logic             write_strobe_n,
    output logic             read_strobe_n,
    output logic [11:0]      data_in
);
    logic combined_style;   // Set by the bench to follow the merged strobe style

    // Idle bus at time zero, data lines not yet meaningful
    initial begin
        cs_n           = 1'b1;
        write_strobe_n = 1'b1;
        read_strobe_n  = 1'b1;
        data_in        = 12'hFFF;
        combined_style = 1'b0;
    end

    // One register write; data held well past the strobe end for the 2-FF capture
    task automatic bus_write(input logic [1:0] addr, input logic [9:0] val);
        @(negedge clk);
        data_in        = {addr, val};
        cs_n           = 1'b0;
        write_strobe_n = 1'b0;          // Low doubles as write direction when merged
        repeat (3) @(negedge clk);
        if (combined_style) begin
            cs_n = 1'b1;
        end else begin
            write_strobe_n = 1'b1;
        end
        repeat (4) @(negedge clk);
        cs_n           = 1'b1;
        write_strobe_n = 1'b1;
        data_in        = ~{addr, val};  // Released lines show no stale value
        repeat (4) @(negedge clk);
    endtask : bus_write

    // One register readback, address on the upper lines during the read
    task automatic bus_read(input logic [1:0] addr, output logic [11:0] val);
        @(negedge clk);
        data_in = {addr, 10'h000};
        cs_n    = 1'b0;
        if (!combined_style) begin
            read_strobe_n = 1'b0;       // Separate strobes only; merged uses high R/W
        end
        repeat (6) @(negedge clk);
        val           = data_out;
        cs_n          = 1'b1;
        read_strobe_n = 1'b1;
        data_in       = ~data_in;
        repeat (4) @(negedge clk);
    endtask : bus_read
endmodule : amrc_host_model

// File: dv/tb.sv
// Self-checking bench for the mode register block
`timescale 1ns/1ps
module tb;
    logic        clk;               // 10 MHz system clock
    logic        rst;               // Async reset, active high
    logic        conv_clk;          // Free-running conversion clock
    logic        cs_n;
    logic        write_strobe_n;
    logic        read_strobe_n;
    logic [11:0] data_in;
    logic [11:0] data_out;
    logic        data_oe_n;
    logic        ref_external;
    logic        powerdown;
    logic [2:0]  conv_input;
    logic        scan_first;
    logic        config_illegal;
    logic [1:0]  test_sel;
    logic        device_in_reset;
    logic        sync_clear;
    logic        twos_complement;
    logic        offset_cal;
    logic        debug_mode;
    logic        read_pulse;
    int          errors;
    int          comparisons;

    amrc_mode_regs dut_u (
        .clk(clk), .rst(rst), .conv_clk(conv_clk), .cs_n(cs_n),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .ref_external(ref_external), .powerdown(powerdown), .conv_input(conv_input),
        .scan_first(scan_first), .config_illegal(config_illegal), .test_sel(test_sel),
        .device_in_reset(device_in_reset), .sync_clear(sync_clear),
        .twos_complement(twos_complement), .offset_cal(offset_cal),
        .debug_mode(debug_mode), .read_pulse(read_pulse)
    );

    amrc_host_model host_u (
        .clk(clk), .data_out(data_out), .cs_n(cs_n), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .data_in(data_in)
    );

    // Clocks; conversion edges fall on system clock falling edges
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        conv_clk = 1'b1;
        forever #400 conv_clk = ~conv_clk;
    end

    // Compare and report
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Two conversion edges so the new setting is surely applied
    task automatic settle;
        repeat (2) @(negedge conv_clk);
        repeat (5) @(negedge clk);
    endtask : settle

    // Readback; output enable and read pulse watched over the whole access
    task automatic rd(input logic [1:0] a, input logic [11:0] e);
        logic [11:0] v;
        int          lo;
        int          pl;
        lo = 0;
        pl = 0;
        fork
            host_u.bus_read(a, v);
            repeat (10) begin
                @(negedge clk);
                if (data_oe_n === 1'b0) lo++;
                if (read_pulse === 1'b1) pl++;
            end
        join
        chk(v, e);
        chk(lo[11:0], 12'h006);
        chk(pl[11:0], 12'h001);
    endtask : rd

    // Packed status of the applied settings
    function automatic logic [11:0] status();
        return {4'h0, test_sel, ref_external, powerdown, device_in_reset,
                twos_complement, offset_cal, debug_mode};
    endfunction : status

    task automatic t_reset;
        settle();
        chk(status(), 12'h004);
        chk({9'h000, conv_input}, 12'h004);
        rd(2'h0, 12'h020);
        rd(2'h1, 12'h000);
    endtask : t_reset

    // Continuous single and differential picks, reserved codes refused
    task automatic t_single;
        logic [9:0] m [8] = '{10'h000, 10'h008, 10'h010, 10'h018,
                              10'h020, 10'h028, 10'h030, 10'h080};
        logic [2:0] e [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h7};
        for (int i = 0; i < 8; i++) begin
            host_u.bus_write(2'h0, m[i]);
            settle();
            chk({9'h000, conv_input}, {9'h000, e[i]});
            chk({11'h000, config_illegal}, {11'h000, e[i] == 3'h7});
            chk({11'h000, scan_first}, 12'h000);
            @(negedge conv_clk);
            repeat (5) @(negedge clk);
            chk({9'h000, conv_input}, {9'h000, e[i]});
        end
    endtask : t_single

    // Autoscan sequences, four slots sampled from slot 0
    task automatic t_scan;
        logic [9:0]  m [6] = '{10'h088, 10'h090, 10'h098, 10'h0A8, 10'h0B0, 10'h0C8};
        logic [11:0] s [6] = '{12'h208, 12'h088, 12'h688, 12'hA28, 12'h148, 12'hB2C};
        int          k;
        for (int i = 0; i < 6; i++) begin
            host_u.bus_write(2'h0, m[i]);
            settle();
            k = 0;
            // Slot 0 code occurs once per plan, so it marks the start
            while (conv_input !== s[i][2:0] && k < 40) begin
                @(negedge clk);
                k++;
            end
            for (int j = 0; j < 4; j++) begin
                chk({9'h000, conv_input}, {9'h000, s[i][j*3 +: 3]});
                chk({11'h000, scan_first}, 12'h001);
                @(negedge conv_clk);
                repeat (5) @(negedge clk);
            end
        end
    endtask : t_scan

    // Reference, power down, test voltages; bus alive while powered down
    task automatic t_fields;
        host_u.bus_write(2'h0, 10'h007);
        settle();
        chk({10'h000, ref_external, powerdown}, 12'h003);
        rd(2'h0, 12'h005);
        for (int t = 0; t < 4; t++) begin
            host_u.bus_write(2'h0, {t[1:0], 8'h00});
            settle();
            chk({10'h000, test_sel}, t[11:0]);
        end
    endtask : t_fields

    // Aux fields, reserved masking and the sync clear pulse
    task automatic t_aux;
        int seen;
        host_u.bus_write(2'h1, 10'h380);
        settle();
        chk({9'h000, twos_complement, offset_cal, debug_mode}, 12'h003);
        rd(2'h1, 12'h380);
        host_u.bus_write(2'h1, 10'h03C);
        rd(2'h1, 12'h000);
        seen = 0;
        fork
            host_u.bus_write(2'h1, 10'h002);
            repeat (30) begin
                @(negedge clk);
                if (sync_clear === 1'b1) seen++;
            end
        join
        chk(seen[11:0], 12'h001);
    endtask : t_aux

    // Reserved addresses leave both registers untouched
    task automatic t_addr;
        host_u.bus_write(2'h0, 10'h008);
        host_u.bus_write(2'h1, 10'h000);
        host_u.bus_write(2'h2, 10'h3FF);
        host_u.bus_write(2'h3, 10'h3FF);
        rd(2'h0, 12'h008);
        rd(2'h1, 12'h000);
    endtask : t_addr

    // Soft reset holds until the bit is written back to zero
    task automatic t_soft;
        host_u.bus_write(2'h0, 10'h018);
        host_u.bus_write(2'h1, 10'h001);
        chk({11'h000, device_in_reset}, 12'h001);
        rd(2'h0, 12'h020);
        host_u.bus_write(2'h0, 10'h008);
        rd(2'h0, 12'h020);
        host_u.bus_write(2'h1, 10'h000);
        chk({11'h000, device_in_reset}, 12'h000);
        host_u.bus_write(2'h0, 10'h008);
        rd(2'h0, 12'h008);
    endtask : t_soft

    // Merged strobe style for writes and reads
    task automatic t_strobe;
        host_u.bus_write(2'h1, 10'h040);
        host_u.combined_style = 1'b1;
        host_u.bus_write(2'h0, 10'h010);
        rd(2'h0, 12'h010);
        rd(2'h1, 12'h040);
        host_u.bus_write(2'h1, 10'h000);
        host_u.combined_style = 1'b0;
        rd(2'h1, 12'h000);
    endtask : t_strobe

    task automatic end_of_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Watchdog well beyond the expected run of under two hundred microseconds
    initial begin
        #2000000;
        errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        errors      = 0;
        comparisons = 0;
        rst         = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_single();
        t_scan();
        t_fields();
        t_aux();
        t_addr();
        t_soft();
        t_strobe();
        end_of_test();
    end
endmodule : tb

// File: hdl/amrc_mode_regs.sv
// Configuration registers, decode and input sequencing of the four-input converter
`timescale 1ns/1ps
// Function
// [R1] Two ten-bit configuration registers
// [R2] Bus bits 10 and 11 select register
// [R3] Bus bits 0 to 9 carry value
// [R4] Code 0 mode, code 1 aux, rest reserved
// [R5] Bit 0 picks internal or external reference
// [R6] Bit 2 powers down; bus stays alive
// [R7] Single-ended pick by bits 4 and 3
// [R8] Differential A or B pair selection
// [R9] Autoscan two, three or four single inputs
// [R10] Autoscan mixing singles with B pair
// [R11] Autoscan alternating both differential pairs
// [R12] Scan bits enable sequencing, else continuous
// [R13] Test bits pick normal, top, mid, bottom
// [R14] Mode reset value selects A pair
// [R15] Aux register bit layout
// [R16] Reset bit restores registers, held until cleared
// [R17] Sync clear bit resets sync generator
// [R18] Strobe style merges read and write strobes
// [R19] Output format twos complement or binary
// [R20] Host avoids reserved codes and bits
// [R21] Capture on strobe end, apply next conversion
module amrc_mode_regs (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        conv_clk,
    input  wire logic        cs_n,
    input  wire logic        write_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic [11:0] data_in,
    output logic [11:0]      data_out,
    output logic             data_oe_n,
    output logic             ref_external,
    output logic             powerdown,
    output logic [2:0]       conv_input,
    output logic             scan_first,
    output logic             config_illegal,
    output logic [1:0]       test_sel,
    output logic             device_in_reset,
    output logic             sync_clear,
    output logic             twos_complement,
    output logic             offset_cal,
    output logic             debug_mode,
    output logic             read_pulse
);
    // Synchroniser stages for all pins
    logic [1:0] cc_s_r, cs_s_r, wr_s_r, rd_s_r;
    logic [11:0] d_s1_r, d_s2_r;
    logic cc_d_r, wr_d_r, rd_d_r;            // Delayed samples for edges
    logic [9:0] mode_r, mode_nxt;            // Mode configuration register
    logic [9:0] aux_r, aux_nxt;              // Auxiliary control register
    logic [9:0] act_r;                       // Mode applied to the converter
    logic       apply_pend_r;                // New mode awaits conversion clock
    logic       sync_clr_r;                  // Sync clear pulse register
    logic [11:0] dout_r;
    logic       oe_n_r, rd_p_r;
    logic       ill_r;
    logic [1:0] test_r;
    logic       scan_r;                      // Legal scan plan applied
    logic       fmt_r;                       // Twos complement output flag
    logic       apply_rst_r;                 // Sequencer restart after a new mode
    logic       cs_act_d;                    // Chip select active, one clock late

    amrc_seq_if sq ();

    // Two flip-flops on every pin before use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cc_s_r <= 2'h0;
            cs_s_r <= 2'h3;
            wr_s_r <= 2'h3;
            rd_s_r <= 2'h3;
            d_s1_r <= 12'h000;
            d_s2_r <= 12'h000;
        end else begin
            cc_s_r <= {cc_s_r[0], conv_clk};
            cs_s_r <= {cs_s_r[0], cs_n};
            wr_s_r <= {wr_s_r[0], write_strobe_n};
            rd_s_r <= {rd_s_r[0], read_strobe_n};
            d_s1_r <= data_in;
            d_s2_r <= d_s1_r;
        end
    end

    // Second-stage copies feed the edge detectors
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cc_d_r <= 1'b0;
            wr_d_r <= 1'b1;
            rd_d_r <= 1'b1;
        end else begin
            cc_d_r <= cc_s_r[1];
            wr_d_r <= wr_s_r[1];
            rd_d_r <= rd_s_r[1];
        end
    end

    // Strobe decode; combined style treats write strobe as direction
    wire cs_act    = ~cs_s_r[1];
    wire style_rw  = aux_r[amrc_pkg::AUX_STROBE_BIT];           // R18
    wire wr_end    = wr_s_r[1] & ~wr_d_r;                        // Rising write strobe
    wire rd_start  = ~rd_s_r[1] & rd_d_r;
    // Combined style: chip select idle this clock and idle the last, while direction low, is a write
    wire cs_end    = cs_s_r[1] & ~cs_act_d;
    wire wr_evt    = style_rw ? (cs_end & ~wr_d_r) : (wr_end & cs_act); // R18 R21
    wire rd_evt    = style_rw ? (cs_act & wr_s_r[1] & ~cs_act_d)
                              : (rd_start & cs_act);             // R18
    wire rd_level  = style_rw ? (cs_act & wr_s_r[1]) : (cs_act & ~rd_s_r[1]);
    wire conv_edge = ~cc_s_r[1] & cc_d_r;                        // Falling edge starts conversion

    // Address decode of the upper data bits
    wire [1:0] addr     = d_s2_r[amrc_pkg::ADDR_MSB:amrc_pkg::ADDR_LSB]; // R2
    wire [9:0] wval     = d_s2_r[amrc_pkg::REG_W-1:0];                    // R3
    wire       wr_mode  = wr_evt & (addr == amrc_pkg::ADDR_MODE);         // R4
    wire       wr_aux   = wr_evt & (addr == amrc_pkg::ADDR_AUX);          // R4
    wire       soft_rst = aux_r[amrc_pkg::AUX_RESET_BIT];                 // R16

    always_ff @(posedge clk or posedge rst) begin
        if (rst) cs_act_d <= 1'b0;
        else     cs_act_d <= cs_act;
    end

    // Next register values; reserved bits are forced to zero
    always_comb begin
        mode_nxt = mode_r;
        aux_nxt  = aux_r;
        if (wr_aux) begin
            aux_nxt = wval & amrc_pkg::AUX_WMASK;               // R15
        end
        if (soft_rst && !(wr_aux && !wval[amrc_pkg::AUX_RESET_BIT])) begin
            // Held in reset: mode stays at its reset value
            mode_nxt = amrc_pkg::MODE_RESET;                    // R16
            if (!wr_aux) aux_nxt = aux_r;
        end else if (wr_mode) begin
            mode_nxt = wval & amrc_pkg::MODE_WMASK;             // R3 R5
        end
        if (wr_aux && wval[amrc_pkg::AUX_RESET_BIT]) begin
            // Reset write: everything but the reset bit returns to reset
            aux_nxt  = amrc_pkg::AUX_RESET | 10'h001;           // R16
            mode_nxt = amrc_pkg::MODE_RESET;                    // R16
        end
    end

    // Register storage; writes work in power down too
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= amrc_pkg::MODE_RESET;                     // R14
            aux_r  <= amrc_pkg::AUX_RESET;
            fmt_r  <= ~amrc_pkg::AUX_RESET[amrc_pkg::AUX_FORMAT_BIT];
        end else begin
            mode_r <= mode_nxt;                                 // R1 R6
            aux_r  <= aux_nxt;                                  // R1
            // Own flop so the output needs no inverter after the register
            fmt_r  <= ~aux_nxt[amrc_pkg::AUX_FORMAT_BIT];        // R19
        end
    end

    // New mode takes effect only at a conversion clock edge or while soft reset is held
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            act_r        <= amrc_pkg::MODE_RESET;
            apply_pend_r <= 1'b0;
        end else if (conv_edge || soft_rst) begin
            act_r        <= mode_r;                             // R21
            // A write landing in this very cycle stays pending
            apply_pend_r <= (mode_nxt != mode_r);
        end else if (mode_nxt != mode_r) begin
            apply_pend_r <= 1'b1;
        end
    end

    // Scan plan decode from the applied mode
    wire       scan  = act_r[amrc_pkg::MODE_SCAN_BIT];
    wire [1:0] dcnt  = {act_r[amrc_pkg::MODE_DIFF_HI_BIT], act_r[amrc_pkg::MODE_DIFF_LO_BIT]};
    wire [1:0] pick  = act_r[amrc_pkg::MODE_PICK_LSB +: 2];
    wire [4:0] code  = {scan, dcnt, pick};
    logic [11:0] plan;
    logic [2:0]  plan_len;

    // Four slots packed low first; unused slots hold the none code
    function automatic logic [11:0] pack4(input logic [2:0] a, input logic [2:0] b,
                                          input logic [2:0] c, input logic [2:0] d);
        pack4 = {d, c, b, a};
    endfunction : pack4

    always_comb begin
        plan     = pack4(3'h7, 3'h7, 3'h7, 3'h7);
        plan_len = 3'h0;
        case (code)
            5'h00, 5'h01, 5'h02, 5'h03: begin
                plan     = pack4({1'b0, pick}, 3'h7, 3'h7, 3'h7);   // R7 R12
                plan_len = 3'h1;
            end
            5'h04: begin
                plan     = pack4(3'h4, 3'h7, 3'h7, 3'h7);           // R8
                plan_len = 3'h1;
            end
            5'h05: begin
                plan     = pack4(3'h5, 3'h7, 3'h7, 3'h7);           // R8
                plan_len = 3'h1;
            end
            5'h11: begin
                plan     = pack4(3'h0, 3'h1, 3'h7, 3'h7);           // R9
                plan_len = 3'h2;
            end
            5'h12: begin
                plan     = pack4(3'h0, 3'h1, 3'h2, 3'h7);           // R9
                plan_len = 3'h3;
            end
            5'h13: begin
                plan     = pack4(3'h0, 3'h1, 3'h2, 3'h3);           // R9
                plan_len = 3'h4;
            end
            5'h15: begin
                plan     = pack4(3'h0, 3'h5, 3'h7, 3'h7);           // R10
                plan_len = 3'h2;
            end
            5'h16: begin
                plan     = pack4(3'h0, 3'h1, 3'h5, 3'h7);           // R10
                plan_len = 3'h3;
            end
            5'h19: begin
                plan     = pack4(3'h4, 3'h5, 3'h7, 3'h7);           // R11
                plan_len = 3'h2;
            end
            default: begin
                // Reserved code: no input converted, flagged instead
                plan     = pack4(3'h7, 3'h7, 3'h7, 3'h7);
                plan_len = 3'h0;
            end
        endcase
    end

    assign sq.slots   = plan;
    assign sq.len     = plan_len;
    assign sq.step    = conv_edge & ~act_r[amrc_pkg::MODE_PD_BIT];  // R6 R12
    assign sq.restart = sync_clr_r | soft_rst | apply_rst_r;       // R17 R21

    // Restart one clock after the apply edge, so slot 0 comes from the new plan
    always_ff @(posedge clk or posedge rst) begin
        if (rst) apply_rst_r <= 1'b0;
        else     apply_rst_r <= conv_edge & apply_pend_r;           // R21
    end

    amrc_sequencer u_seq (
        .clk (clk),
        .rst (rst),
        .sq  (sq)
    );

    // Sync clear pulse: one cycle per separate-strobe write of the bit, one per clock the write event holds in merged style
    always_ff @(posedge clk or posedge rst) begin
        if (rst) sync_clr_r <= 1'b0;
        else     sync_clr_r <= wr_aux & wval[amrc_pkg::AUX_SYNC_BIT];  // R17
    end

    // Readback of the addressed register on reads, bus kept alive in power down
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout_r <= 12'h000;
            oe_n_r <= 1'b1;
            rd_p_r <= 1'b0;
        end else begin
            oe_n_r <= ~rd_level;                                    // R6
            rd_p_r <= rd_evt;
            if (rd_evt) dout_r <= {2'h0, (addr == amrc_pkg::ADDR_AUX) ? aux_r : mode_r};
        end
    end

    // Status outputs registered from applied state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ill_r  <= 1'b0;
            test_r <= amrc_pkg::TEST_NORMAL;
            scan_r <= 1'b0;
        end else begin
            ill_r  <= (plan_len == 3'h0);
            scan_r <= (plan_len != 3'h0) & scan;                    // R12
            test_r <= act_r[amrc_pkg::MODE_TEST_LSB +: 2];          // R13
        end
    end

    assign data_out        = dout_r;
    assign data_oe_n       = oe_n_r;
    assign ref_external    = act_r[amrc_pkg::MODE_REF_BIT];          // R5
    assign powerdown       = act_r[amrc_pkg::MODE_PD_BIT];           // R6
    assign conv_input      = sq.cur;
    assign scan_first      = scan_r;                                // R12
    assign config_illegal  = ill_r;
    assign test_sel        = test_r;
    assign device_in_reset = aux_r[amrc_pkg::AUX_RESET_BIT];         // R16
    assign sync_clear      = sync_clr_r;
    assign twos_complement = fmt_r;                                  // R19
    assign offset_cal      = aux_r[amrc_pkg::AUX_OFFSET_BIT];        // R15
    assign debug_mode      = aux_r[amrc_pkg::AUX_DBG_BIT];           // R15
    assign read_pulse      = rd_p_r;

    // Checks on the register behaviour
    AST_MODE_RESET: assert property (@(posedge clk) disable iff (rst) // R16
        $rose(aux_r[0]) |-> mode_r == amrc_pkg::MODE_RESET)
        else $error("mode not restored by soft reset");
    AST_MODE_WRITE: assert property (@(posedge clk) disable iff (rst) // R3
        wr_mode && !soft_rst |=> mode_r == ($past(wval) & amrc_pkg::MODE_WMASK))
        else $error("mode write not stored");
    AST_AUX_RSVD: assert property (@(posedge clk) disable iff (rst) // R15
        (aux_r & ~amrc_pkg::AUX_WMASK) == 10'h000)
        else $error("aux reserved bits set");
    AST_RSVD_ADDR: assert property (@(posedge clk) disable iff (rst) // R4
        wr_evt && addr[1] |=> $stable(mode_r) && $stable(aux_r))
        else $error("reserved address changed a register");
    AST_SYNC_PULSE: assert property (@(posedge clk) disable iff (rst) // R17
        sync_clr_r |=> !sync_clr_r || $past(wr_aux))
        else $error("sync clear pulse too long");
    AST_APPLY: assert property (@(posedge clk) disable iff (rst) // R21
        !conv_edge && !soft_rst |=> $stable(act_r))
        else $error("mode applied without conversion edge");
    AST_FORMAT: assert property (@(posedge clk) disable iff (rst) // R19
        twos_complement != aux_r[amrc_pkg::AUX_FORMAT_BIT])
        else $error("output format wrong");
    AST_PD_HOLD: assert property (@(posedge clk) disable iff (rst) // R6
        act_r[2] && !sq.restart |=> $stable(sq.cur))
        else $error("sequencer moved in power down");
    AST_RESTART_SLOT0: assert property (@(posedge clk) disable iff (rst) // R21
        sq.restart |=> sq.first)
        else $error("sequencer not at slot 0 after restart");
endmodule : amrc_mode_regs

// File: hdl/amrc_pkg.sv
// Package with register layout, reset values and codes for the mode register block
package amrc_pkg;
    localparam int DATA_W           = 12;   // Parallel data bus width
    localparam int REG_W            = 10;   // Width of each configuration register
    localparam int ADDR_LSB         = 10;   // Register select low bit on the bus
    localparam int ADDR_MSB         = 11;   // Register select high bit on the bus
    localparam logic [1:0] ADDR_MODE = 2'h0; // Mode configuration register
    localparam logic [1:0] ADDR_AUX  = 2'h1; // Auxiliary control register
    // Mode configuration register fields
    localparam int MODE_REF_BIT     = 0;
    localparam int MODE_PD_BIT      = 2;
    localparam int MODE_PICK_LSB    = 3;
    localparam int MODE_DIFF_LO_BIT = 5;
    localparam int MODE_DIFF_HI_BIT = 6;
    localparam int MODE_SCAN_BIT    = 7;
    localparam int MODE_TEST_LSB    = 8;
    localparam logic [9:0] MODE_RESET = 10'h020; // Single A differential pair
    localparam logic [9:0] MODE_WMASK = 10'h3FD; // Bit 1 reserved
    // Auxiliary control register fields
    localparam int AUX_RESET_BIT    = 0;
    localparam int AUX_SYNC_BIT     = 1;
    localparam int AUX_STROBE_BIT   = 6;
    localparam int AUX_FORMAT_BIT   = 7;
    localparam int AUX_OFFSET_BIT   = 8;
    localparam int AUX_DBG_BIT      = 9;
    localparam logic [9:0] AUX_RESET  = 10'h000;
    localparam logic [9:0] AUX_WMASK  = 10'h3C3; // Bits 2 to 5 reserved
    // Input codes for the current conversion slot
    typedef enum logic [2:0] {
        AMRC_IN_A_POS  = 3'h0,
        AMRC_IN_A_NEG  = 3'h1,
        AMRC_IN_B_POS  = 3'h2,
        AMRC_IN_B_NEG  = 3'h3,
        AMRC_IN_A_DIFF = 3'h4,
        AMRC_IN_B_DIFF = 3'h5,
        AMRC_IN_NONE   = 3'h7
    } amrc_input_t;
    // Test voltage selection codes
    localparam logic [1:0] TEST_NORMAL = 2'h0;
    localparam logic [1:0] TEST_TOP    = 2'h1;
    localparam logic [1:0] TEST_MID    = 2'h2;
    localparam logic [1:0] TEST_BOTTOM = 2'h3;
    localparam int SEQ_MAX          = 4;    // Longest autoscan sequence
endpackage : amrc_pkg

// File: hdl/amrc_seq_if.sv
// Interface carrying the scan plan from the decoder to the sequencer
`timescale 1ns/1ps
interface amrc_seq_if;
    logic [11:0] slots;     // Four 3-bit slot codes, slot 0 lowest
    logic [2:0]  len;       // Number of slots, 0 for an illegal code
    logic        step;      // Advance one slot
    logic        restart;   // Return to slot 0
    logic [2:0]  cur;       // Current slot code
    logic        first;     // Current slot is slot 0
    modport ctrl (output slots, output len, output step, output restart,
                  input cur, input first);
    modport seq  (input slots, input len, input step, input restart,
                  output cur, output first);
endinterface : amrc_seq_if

// File: hdl/amrc_sequencer.sv
// Slot sequencer walking the autoscan plan one conversion at a time
`timescale 1ns/1ps
module amrc_sequencer (
    input  wire logic   clk,
    input  wire logic   rst,
    amrc_seq_if.seq     sq
);
    logic [1:0] idx_r;      // Current slot index
    logic [1:0] idx_nxt;    // Next slot index
    logic [2:0] cur_r;      // Registered slot code
    logic       wrap;       // Last slot reached

    // Wrap at plan length so a shorter plan never reads stale slots
    assign wrap    = ({1'b0, idx_r} + 3'h1) >= sq.len;
    assign idx_nxt = (sq.restart || wrap) ? 2'h0 : idx_r + 2'h1;

    // Index and code advance on each conversion step
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_r <= 2'h0;
            cur_r <= 3'h7;
        end else if (sq.restart || sq.step) begin
            idx_r <= sq.restart ? 2'h0 : idx_nxt;
            cur_r <= sq.slots[3*(sq.restart ? 2'h0 : idx_nxt) +: 3];
        end
    end

    assign sq.cur   = cur_r;
    assign sq.first = (idx_r == 2'h0);
endmodule : amrc_sequencer
